// ==== pulse_density_clock_ctrl.sv ====
// pulse-density clock configuration and two missing-clock detectors
// assumes a byte register port from the control-bus front end, clocks from pins
// Summary of operation
// - config bit 2 picks sampling edge, 0 rising, 1 falling.
// - config bit 1 sets input clock pin direction, 1 drives it.
// - config bit 0 sets output clock pin direction, 1 drives it.
// - bit 7 at 0x1D powers the pulse-density input divider.
// - bit 7 at 0x1E powers the direct-stream divider.
// - bit 7 at 0x21 requests memory reload on fault restarts.
// - bit 4 at 0x21 picks detector one clock: serial or pulse-density.
// - bits 3-2 at 0x21 pick detector two clock: dac, adc, pll.
// - bit 1 at 0x21 enables detector one.
// - bit 0 at 0x21 enables detector two.
// - 0x22 holds detector one timeout in 5-3, two in 2-0.
// - timeout codes map 11,22,44,87,174,350,700 ms and 1.2 s.
// - enabled detector without edges for timeout shuts device down.
// - clock error sets fault status bit 0; host clears it first.
// - 0x21 resets to 0x03.
// - 0x22 resets to 0x3F.
// - interrupt pin mode 4 drives divider output onto the pin.
`timescale 1ns/10ps
module pulse_density_clock_ctrl
  import pulse_density_clock_pkg::*;
(
  // clock, reset, enable
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       clk_en_in,
  // register port
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  // watched clocks
  input  wire logic       serial_audio_clock_in,
  input  wire logic       pulse_density_clock_in,
  input  wire logic       dac_mod_clock_in,
  input  wire logic       adc_mod_clock_in,
  input  wire logic       pll_clock_in,
  // pulse-density pins
  input  wire logic       pd_input_clock_pin_in,
  output logic            pd_input_clock_pin_out,
  output logic            pd_input_clock_pin_oe_out,
  input  wire logic       pd_output_clock_pin_in,
  output logic            pd_output_clock_pin_out,
  output logic            pd_output_clock_pin_oe_out,
  input  wire logic       pd_input_divider_clk_in,
  input  wire logic       pd_data_in,
  output logic            pd_data_out,
  // divider, memory and fault controls
  output logic            pd_in_divider_power_out,
  output logic            stream_divider_power_out,
  output logic            mem_reload_request_out,
  output logic            shutdown_out,
  // interrupt pin
  output logic            irq_pin_out,
  output logic            irq_pin_oe_out
);
  localparam int CNT_W = 26;

  function automatic logic [CNT_W-1:0] code_to_cycles(input logic [2:0] code);
    code_to_cycles = CNT_W'(TIMEOUT_CYC[code]);
  endfunction

  logic [7:0] pd_cfg_q;
  logic [7:0] pd_div_q;
  logic [7:0] stream_div_q;
  logic [7:0] err_ctrl_q;
  logic [7:0] err_time_q;
  logic [7:0] irq_cfg_q;
  logic       clk_err_q;
  logic       shutdown_q;
  det_state_t det1_q;
  det_state_t det2_q;

  // register writes
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pd_cfg_q     <= PD_CFG_RST;
      pd_div_q     <= PD_DIV_RST;
      stream_div_q <= STREAM_DIV_RST;
      err_ctrl_q   <= ERR_CTRL_RST;
      err_time_q   <= ERR_TIME_RST;
      irq_cfg_q    <= IRQ_CFG_RST;
    end else if (clk_en_in && reg_wr_in) begin
      case (reg_addr_in)
        PD_CFG_ADDR: begin
          pd_cfg_q <= reg_wdata_in;
        end
        PD_DIV_ADDR: begin
          pd_div_q <= reg_wdata_in;
        end
        STREAM_DIV_ADDR: begin
          stream_div_q <= reg_wdata_in;
        end
        ERR_CTRL_ADDR: begin
          err_ctrl_q <= reg_wdata_in;
        end
        ERR_TIME_ADDR: begin
          err_time_q <= reg_wdata_in;
        end
        IRQ_CFG_ADDR: begin
          irq_cfg_q <= reg_wdata_in;
        end
        default: begin
        end
      endcase
    end
  end

  // register reads
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (clk_en_in && reg_rd_in) begin
      case (reg_addr_in)
        PD_CFG_ADDR:     reg_rdata_out <= pd_cfg_q;
        PD_DIV_ADDR:     reg_rdata_out <= pd_div_q;
        STREAM_DIV_ADDR: reg_rdata_out <= stream_div_q;
        ERR_CTRL_ADDR:   reg_rdata_out <= err_ctrl_q;
        ERR_TIME_ADDR:   reg_rdata_out <= err_time_q;
        IRQ_CFG_ADDR:    reg_rdata_out <= irq_cfg_q;
        FAULT_STAT_ADDR: reg_rdata_out <= {7'h00, clk_err_q};
        default:         reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // source selection
  logic d1_src;
  logic d2_src;
  always_comb begin
    d1_src = err_ctrl_q[DET1_SRC_BIT] ? pulse_density_clock_in
                                      : serial_audio_clock_in;
    case (err_ctrl_q[DET2_SRC_LSB +: 2])
      2'h0:    d2_src = dac_mod_clock_in;
      2'h1:    d2_src = adc_mod_clock_in;
      2'h2:    d2_src = pll_clock_in;
      default: d2_src = 1'b0;
    endcase
  end

  logic d1_edge;
  logic d2_edge;
  clk_sync_edge u_sync1 (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_in),
    .enable_in (clk_en_in),
    .async_in  (d1_src),
    .edge_out  (d1_edge)
  );
  clk_sync_edge u_sync2 (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_in),
    .enable_in (clk_en_in),
    .async_in  (d2_src),
    .edge_out  (d2_edge)
  );

  logic d1_en;
  logic d2_en;
  logic d1_exp;
  logic d2_exp;
  assign d1_en = err_ctrl_q[DET1_EN_BIT];
  assign d2_en = err_ctrl_q[DET2_EN_BIT];

  clk_absence_timer #(.CNT_W(CNT_W)) u_timer1 (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .enable_in   (clk_en_in),
    .active_in   (det1_q == DET_WATCH),
    .edge_in     (d1_edge),
    .limit_in    (code_to_cycles(err_time_q[DET1_TIME_LSB +: 3])),
    .expired_out (d1_exp)
  );
  clk_absence_timer #(.CNT_W(CNT_W)) u_timer2 (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .enable_in   (clk_en_in),
    .active_in   (det2_q == DET_WATCH),
    .edge_in     (d2_edge),
    .limit_in    (code_to_cycles(err_time_q[DET2_TIME_LSB +: 3])),
    .expired_out (d2_exp)
  );

  function automatic det_state_t det_next(input det_state_t s, input logic en,
                                          input logic expired);
    case (s)
      DET_IDLE:  det_next = en ? DET_WATCH : DET_IDLE;
      DET_WATCH: det_next = !en ? DET_IDLE : (expired ? DET_FAULT : DET_WATCH);
      DET_FAULT: det_next = en ? DET_FAULT : DET_IDLE;
      default:   det_next = DET_IDLE;
    endcase
  endfunction

  // detector state machines
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      det1_q <= DET_IDLE;
      det2_q <= DET_IDLE;
    end else if (clk_en_in) begin
      det1_q <= det_next(det1_q, d1_en, d1_exp);
      det2_q <= det_next(det2_q, d2_en, d2_exp);
    end
  end

  logic fault_evt;
  logic stat_clr;
  assign fault_evt = (det1_q == DET_WATCH && d1_en && d1_exp)
                  || (det2_q == DET_WATCH && d2_en && d2_exp);
  assign stat_clr  = reg_wr_in && reg_addr_in == FAULT_STAT_ADDR
                  && !reg_wdata_in[CLK_ERR_BIT];

  // sticky clock error, set wins over clear
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      clk_err_q <= 1'b0;
    end else if (clk_en_in) begin
      if (fault_evt) begin
        clk_err_q <= 1'b1;
      end else if (stat_clr) begin
        clk_err_q <= 1'b0;
      end
    end
  end

  // shutdown held until the flag is cleared
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      shutdown_q <= 1'b0;
    end else if (clk_en_in) begin
      if (fault_evt) begin
        shutdown_q <= 1'b1;
      end else if (stat_clr) begin
        shutdown_q <= 1'b0;
      end
    end
  end

  // pulse-density data capture on chosen edge of synchronised clock
  logic pdc_meta_q;
  logic pdc_sync_q;
  logic pdc_last_q;
  logic pdd_meta_q;
  logic pdd_sync_q;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pdc_meta_q <= 1'b0;
      pdc_sync_q <= 1'b0;
      pdc_last_q <= 1'b0;
      pdd_meta_q <= 1'b0;
      pdd_sync_q <= 1'b0;
    end else if (clk_en_in) begin
      pdc_meta_q <= pd_input_clock_pin_in;
      pdc_sync_q <= pdc_meta_q;
      pdc_last_q <= pdc_sync_q;
      pdd_meta_q <= pd_data_in;
      pdd_sync_q <= pdd_meta_q;
    end
  end

  logic pd_take;
  assign pd_take = pd_cfg_q[EDGE_SEL_BIT] ? (pdc_last_q && !pdc_sync_q)
                                          : (!pdc_last_q && pdc_sync_q);
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pd_data_out <= 1'b0;
    end else if (clk_en_in && pd_take) begin
      pd_data_out <= pdd_sync_q;
    end
  end

  // pin drivers and control outputs
  assign pd_input_clock_pin_oe_out  = pd_cfg_q[IN_DIR_BIT];
  assign pd_input_clock_pin_out     = pd_input_divider_clk_in;
  assign pd_output_clock_pin_oe_out = pd_cfg_q[OUT_DIR_BIT];
  assign pd_output_clock_pin_out    = pd_input_divider_clk_in;
  assign pd_in_divider_power_out    = pd_div_q[DIV_POWER_BIT];
  assign stream_divider_power_out   = stream_div_q[DIV_POWER_BIT];
  assign mem_reload_request_out     = shutdown_q && err_ctrl_q[MEM_RELOAD_BIT];
  assign shutdown_out               = shutdown_q;
  assign irq_pin_oe_out             = irq_cfg_q[2:0] == IRQ_MODE_DIVIDER;
  assign irq_pin_out                = irq_pin_oe_out && pd_input_divider_clk_in;

  // checks
  flag_follows_fault_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && fault_evt |=> clk_err_q && shutdown_q)
    else $error("fault did not set flag");
  set_beats_clear_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && fault_evt && stat_clr |=> clk_err_q)
    else $error("clear beat fault set");
  clear_drops_flag_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && stat_clr && !fault_evt |=> !clk_err_q && !shutdown_q)
    else $error("clear did not drop flag");
  disabled_no_fault_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !d1_en && !d2_en |-> !fault_evt)
    else $error("fault while detectors off");
  det1_off_idle_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && !d1_en |=> det1_q == DET_IDLE)
    else $error("detector one not idle");
  det2_off_idle_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && !d2_en |=> det2_q == DET_IDLE)
    else $error("detector two not idle");
  one_expiry_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && det1_q == DET_WATCH && d1_en && d1_exp |=> det1_q == DET_FAULT)
    else $error("detector one missed expiry");
  two_expiry_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && det2_q == DET_WATCH && d2_en && d2_exp |=> det2_q == DET_FAULT)
    else $error("detector two missed expiry");
  ctrl_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && reg_wr_in && reg_addr_in == ERR_CTRL_ADDR
    |=> err_ctrl_q == $past(reg_wdata_in))
    else $error("control write lost");
  time_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && reg_wr_in && reg_addr_in == ERR_TIME_ADDR
    |=> err_time_q == $past(reg_wdata_in))
    else $error("timeout write lost");
  in_dir_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && reg_wr_in && reg_addr_in == PD_CFG_ADDR
    |=> pd_input_clock_pin_oe_out == $past(reg_wdata_in[IN_DIR_BIT]))
    else $error("input pin direction wrong");
  out_dir_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && reg_wr_in && reg_addr_in == PD_CFG_ADDR
    |=> pd_output_clock_pin_oe_out == $past(reg_wdata_in[OUT_DIR_BIT]))
    else $error("output pin direction wrong");
  div_power_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && reg_wr_in && reg_addr_in == PD_DIV_ADDR
    |=> pd_in_divider_power_out == $past(reg_wdata_in[DIV_POWER_BIT]))
    else $error("input divider power wrong");
  stream_power_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && reg_wr_in && reg_addr_in == STREAM_DIV_ADDR
    |=> stream_divider_power_out == $past(reg_wdata_in[DIV_POWER_BIT]))
    else $error("stream divider power wrong");
  edge_capture_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && pd_take |=> pd_data_out == $past(pdd_sync_q))
    else $error("data not captured");
  shutdown_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    shutdown_q && !stat_clr |=> shutdown_q)
    else $error("shutdown dropped");
  irq_mode_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    irq_cfg_q[2:0] != IRQ_MODE_DIVIDER |-> !irq_pin_oe_out)
    else $error("irq pin driven in wrong mode");
  frozen_state_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !clk_en_in |=> $stable(err_ctrl_q) && $stable(clk_err_q) && $stable(shutdown_q))
    else $error("state moved while frozen");
endmodule

// ==== pulse_density_clock_pkg.sv ====
// package: register map, field positions, reset values and timeout counts
// assumes a 40 MHz system clock
package pulse_density_clock_pkg;
  localparam logic [7:0] PD_CFG_ADDR      = 8'h1c;
  localparam logic [7:0] PD_DIV_ADDR      = 8'h1d;
  localparam logic [7:0] STREAM_DIV_ADDR  = 8'h1e;
  localparam logic [7:0] ERR_CTRL_ADDR    = 8'h21;
  localparam logic [7:0] ERR_TIME_ADDR    = 8'h22;
  localparam logic [7:0] IRQ_CFG_ADDR     = 8'h23;
  localparam logic [7:0] FAULT_STAT_ADDR  = 8'h05;
  localparam logic [7:0] PD_CFG_RST       = 8'h00;
  localparam logic [7:0] PD_DIV_RST       = 8'h08;
  localparam logic [7:0] STREAM_DIV_RST   = 8'h08;
  localparam logic [7:0] ERR_CTRL_RST     = 8'h03;
  localparam logic [7:0] ERR_TIME_RST     = 8'h3f;
  localparam logic [7:0] IRQ_CFG_RST      = 8'h21;
  localparam int EDGE_SEL_BIT   = 2;
  localparam int IN_DIR_BIT     = 1;
  localparam int OUT_DIR_BIT    = 0;
  localparam int DIV_POWER_BIT  = 7;
  localparam int MEM_RELOAD_BIT = 7;
  localparam int DET1_SRC_BIT   = 4;
  localparam int DET2_SRC_LSB   = 2;
  localparam int DET1_EN_BIT    = 1;
  localparam int DET2_EN_BIT    = 0;
  localparam int DET1_TIME_LSB  = 3;
  localparam int DET2_TIME_LSB  = 0;
  localparam int CLK_ERR_BIT    = 0;
  localparam logic [2:0] IRQ_MODE_DIVIDER = 3'h4;
  localparam int CLK_HZ = 40_000_000;
  localparam int TIMEOUT_US [8] = '{11_000, 22_000, 44_000, 87_000,
                                     174_000, 350_000, 700_000, 1_200_000};
  localparam int TIMEOUT_CYC [8] = '{TIMEOUT_US[0] * (CLK_HZ / 1_000_000),
                                      TIMEOUT_US[1] * (CLK_HZ / 1_000_000),
                                      TIMEOUT_US[2] * (CLK_HZ / 1_000_000),
                                      TIMEOUT_US[3] * (CLK_HZ / 1_000_000),
                                      TIMEOUT_US[4] * (CLK_HZ / 1_000_000),
                                      TIMEOUT_US[5] * (CLK_HZ / 1_000_000),
                                      TIMEOUT_US[6] * (CLK_HZ / 1_000_000),
                                      TIMEOUT_US[7] * (CLK_HZ / 1_000_000)};
  typedef enum logic [1:0] {DET_IDLE, DET_WATCH, DET_FAULT} det_state_t;
endpackage

// ==== clk_sync_edge.sv ====
// two-flop synchroniser with edge detect of the synchronised level
// assumes the input is asynchronous to clock_in
`timescale 1ns/10ps
module clk_sync_edge (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic enable_in,
  // async level in, edge pulse out
  input  wire logic async_in,
  output logic      edge_out
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else if (enable_in) begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign edge_out = sync_q ^ last_q;
endmodule

// ==== clk_absence_timer.sv ====
// absence timer for one watched clock: counts cycles since last edge
// assumes edge_in is already synchronised; limit is the timeout cycle count
`timescale 1ns/10ps
module clk_absence_timer #(
  parameter int CNT_W = 26
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic             enable_in,
  // control
  input  wire logic             active_in,
  input  wire logic             edge_in,
  input  wire logic [CNT_W-1:0] limit_in,
  // result
  output logic                  expired_out
);
  logic [CNT_W-1:0] count_q;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      count_q <= '0;
    end else if (enable_in) begin
      if (!active_in || edge_in) begin
        count_q <= '0;
      end else if (count_q < limit_in) begin
        count_q <= count_q + 1'b1;
      end
    end
  end
  assign expired_out = active_in && (count_q >= limit_in);
endmodule

// ==== pulse_density_clock_partner.sv ====
// far-side model: watched clocks, pulse-density pin clock, data and divider clock
// assumes clock_in is the 40 MHz system clock; clocks stand still low when run_in is low
`timescale 1ns/10ps
module pulse_density_clock_partner (
  // clock and control
  input  wire logic clock_in,
  input  wire logic run_in,
  // watched clocks
  output logic      serial_audio_clock_out,
  output logic      pulse_density_clock_out,
  output logic      dac_mod_clock_out,
  output logic      adc_mod_clock_out,
  output logic      pll_clock_out,
  // pins and data
  output logic      pd_in_pin_drive_out,
  output logic      pd_out_pin_drive_out,
  output logic      divider_clock_out,
  output logic      pd_data_out
);
  logic [4:0] cnt_q = 5'h00;

  always @(posedge clock_in) begin
    cnt_q <= #1 cnt_q + 5'h01;
  end

  // pin clock period 32 cycles: rises at 16, falls at 0
  assign pd_in_pin_drive_out     = run_in & cnt_q[4];
  assign pd_out_pin_drive_out    = run_in & cnt_q[3];
  assign divider_clock_out       = run_in & cnt_q[1];
  assign serial_audio_clock_out  = run_in & cnt_q[2];
  assign pulse_density_clock_out = run_in & cnt_q[3];
  assign dac_mod_clock_out       = run_in & cnt_q[1];
  assign adc_mod_clock_out       = run_in & cnt_q[2];
  assign pll_clock_out           = run_in & cnt_q[0];
  // data high around the rising edge, low around the falling edge
  assign pd_data_out             = cnt_q[4] ^ cnt_q[3];
endmodule

// ==== pulse_density_clock_ctrl_tb_top.sv ====
// self-checking bench for the clock configuration and missing-clock block
// assumes the partner model supplies every watched, pin and divider clock, the bench makes clock_in; registers reached by strobes
`timescale 1ns/10ps
module pulse_density_clock_ctrl_tb_top;
  import pulse_density_clock_pkg::*;
  logic       clock_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       clk_en_in = 1'b1;
  logic       reg_wr_in = 1'b0;
  logic       reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic       run = 1'b1;
  logic       sa_clk, pd_clk, dac_clk, adc_clk, pll_clk, div_clk, pd_data;
  logic       p_in_drv, p_out_drv, in_pin, out_pin;
  logic       in_out, in_oe, out_out, out_oe, data_out;
  logic       pd_pwr, st_pwr, mem_rel, shutdown, irq_out, irq_oe;
  logic [1:0] mon_sel = 2'h0;
  logic       mon;
  int         errors = 0;
  int         total_checks = 0;
  int         cycles = 0;

  initial begin
    forever #12.5 clock_in = ~clock_in;
  end

  assign in_pin  = in_oe ? in_out : p_in_drv;
  assign out_pin = out_oe ? out_out : p_out_drv;
  always_comb begin
    case (mon_sel)
      2'h1:    mon = in_out;
      2'h2:    mon = out_out;
      default: mon = irq_out;
    endcase
  end

  pulse_density_clock_partner partner (.clock_in(clock_in), .run_in(run),
    .serial_audio_clock_out(sa_clk), .pulse_density_clock_out(pd_clk),
    .dac_mod_clock_out(dac_clk), .adc_mod_clock_out(adc_clk), .pll_clock_out(pll_clk),
    .pd_in_pin_drive_out(p_in_drv), .pd_out_pin_drive_out(p_out_drv),
    .divider_clock_out(div_clk), .pd_data_out(pd_data));

  pulse_density_clock_ctrl dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .serial_audio_clock_in(sa_clk), .pulse_density_clock_in(pd_clk),
    .dac_mod_clock_in(dac_clk), .adc_mod_clock_in(adc_clk), .pll_clock_in(pll_clk),
    .pd_input_clock_pin_in(in_pin), .pd_input_clock_pin_out(in_out),
    .pd_input_clock_pin_oe_out(in_oe), .pd_output_clock_pin_in(out_pin),
    .pd_output_clock_pin_out(out_out), .pd_output_clock_pin_oe_out(out_oe),
    .pd_input_divider_clk_in(div_clk), .pd_data_in(pd_data), .pd_data_out(data_out),
    .pd_in_divider_power_out(pd_pwr), .stream_divider_power_out(st_pwr),
    .mem_reload_request_out(mem_rel), .shutdown_out(shutdown),
    .irq_pin_out(irq_out), .irq_pin_oe_out(irq_oe));

  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      results();
    end
  end

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1 reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(posedge clock_in);
    #1 reg_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    #1 reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(posedge clock_in);
    #1 reg_rd_in = 1'b0;
    chk8($sformatf("reg %h", a), exp, reg_rdata_out);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask

  task automatic toggles(input string name, input logic [1:0] sel);
    logic prev;
    int   n;
    mon_sel = sel;
    n = 0;
    #1 prev = mon;
    repeat (32) begin
      @(posedge clock_in);
      #2 if (mon !== prev) n++;
      prev = mon;
    end
    chk1(name, 1'b1, n > 0);
  endtask

  localparam logic [7:0] ADDRS [7] = '{8'h1c, 8'h1d, 8'h1e, 8'h21, 8'h22, 8'h23, 8'h05};
  localparam logic [7:0] RSTS  [7] = '{8'h00, 8'h08, 8'h08, 8'h03, 8'h3f, 8'h21, 8'h00};

  initial begin
    repeat (3) @(posedge clock_in);
    #1 rst_n_in = 1'b1;
    for (int i = 0; i < 7; i++) rd(ADDRS[i], RSTS[i]);
    chk1("in oe", 1'b0, in_oe);
    chk1("out oe", 1'b0, out_oe);
    chk1("in div power", 1'b0, pd_pwr);
    chk1("stream power", 1'b0, st_pwr);
    chk1("irq oe", 1'b0, irq_oe);
    chk32("limit one", 32'h02dc_6c00, 32'(dut.u_timer1.limit_in));
    chk32("limit two", 32'h02dc_6c00, 32'(dut.u_timer2.limit_in));
    // unmapped place ignores writes and reads zero
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00);
    // pin directions, reserved bits kept at reset values
    wr(PD_CFG_ADDR, 8'h02);
    wait_cyc(2);
    chk1("in oe", 1'b1, in_oe);
    chk1("out oe", 1'b0, out_oe);
    toggles("in pin out", 2'h1);
    wr(PD_CFG_ADDR, 8'h01);
    wait_cyc(2);
    chk1("in oe", 1'b0, in_oe);
    chk1("out oe", 1'b1, out_oe);
    toggles("out pin out", 2'h2);
    // sampling edge of the data
    wr(PD_CFG_ADDR, 8'h00);
    wait_cyc(96);
    chk1("data rising", 1'b1, data_out);
    wr(PD_CFG_ADDR, 8'h04);
    wait_cyc(96);
    chk1("data falling", 1'b0, data_out);
    rd(PD_CFG_ADDR, 8'h04);
    // divider power bits
    wr(PD_DIV_ADDR, 8'h88);
    wr(STREAM_DIV_ADDR, 8'h88);
    wait_cyc(2);
    chk1("in div power", 1'b1, pd_pwr);
    chk1("stream power", 1'b1, st_pwr);
    rd(PD_DIV_ADDR, 8'h88);
    rd(STREAM_DIV_ADDR, 8'h88);
    // a frozen clock enable takes no write
    clk_en_in = 1'b0;
    wr(PD_DIV_ADDR, 8'h08);
    #1 clk_en_in = 1'b1;
    wait_cyc(2);
    chk1("frozen power", 1'b1, pd_pwr);
    wr(PD_DIV_ADDR, 8'h08);
    wr(STREAM_DIV_ADDR, 8'h08);
    wait_cyc(2);
    chk1("in div power", 1'b0, pd_pwr);
    chk1("stream power", 1'b0, st_pwr);
    // detectors off, sources and reload set, clocks stopped
    wr(ERR_CTRL_ADDR, 8'h9c);
    rd(ERR_CTRL_ADDR, 8'h9c);
    wr(ERR_TIME_ADDR, 8'h00);
    rd(ERR_TIME_ADDR, 8'h00);
    chk32("limit one", 32'h0006_b6c0, 32'(dut.u_timer1.limit_in));
    chk32("limit two", 32'h0006_b6c0, 32'(dut.u_timer2.limit_in));
    #1 run = 1'b0;
    wait_cyc(3000);
    chk1("idle shutdown", 1'b0, shutdown);
    chk1("reload request", 1'b0, mem_rel);
    rd(FAULT_STAT_ADDR, 8'h00);
    // enabled with clocks stopped: absence counted, no early fault
    wr(ERR_CTRL_ADDR, 8'h03);
    wait_cyc(1000);
    chk1("absence count", 1'b1, dut.u_timer1.count_q > 26'h0384);
    chk1("absence count two", 1'b1, dut.u_timer2.count_q > 26'h0384);
    chk1("early shutdown", 1'b0, shutdown);
    // clocks running again restart both counts
    #1 run = 1'b1;
    wait_cyc(2000);
    chk1("early shutdown", 1'b0, shutdown);
    chk1("count restart", 1'b1, dut.u_timer1.count_q < 26'h0010);
    chk1("count restart two", 1'b1, dut.u_timer2.count_q < 26'h0010);
    wr(ERR_TIME_ADDR, 8'h2a);
    rd(ERR_TIME_ADDR, 8'h2a);
    chk32("limit one", 32'h00d5_9f80, 32'(dut.u_timer1.limit_in));
    chk32("limit two", 32'h001a_db00, 32'(dut.u_timer2.limit_in));
    wr(FAULT_STAT_ADDR, 8'h00);
    rd(FAULT_STAT_ADDR, 8'h00);
    // interrupt pin carries the divider clock in mode 4
    wr(IRQ_CFG_ADDR, 8'h24);
    wait_cyc(2);
    chk1("irq oe", 1'b1, irq_oe);
    toggles("irq out", 2'h0);
    wr(IRQ_CFG_ADDR, 8'h21);
    wait_cyc(2);
    chk1("irq oe", 1'b0, irq_oe);
    results();
  end
endmodule
